// ### rtl/ee_params.svh
/*
 Constants of the serial EEPROM bus slave: memory geometry, address byte fields and write cycle timing.
 Assumes a 100 MHz system clock; included by bare name.
*/
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH

`define EE_CLK_MHZ 100
`define EE_MEM_BYTES 1024
`define EE_ADDR_W 10
`define EE_PAGE_BYTES 4'h8
`define EE_FIFO_DEPTH 8
`define EE_FIFO_W 18
// address byte fields
`define EE_AB_TYPE_HI 7
`define EE_AB_TYPE_LO 4
`define EE_AB_CS 3
`define EE_AB_PAGE_HI 2
`define EE_AB_PAGE_LO 1
`define EE_AB_DIR 0
`define EE_DIR_READ 1'b1
`define EE_PROT_BIT 9
`define EE_BITS_PER_BYTE 4'h8
// write cycle times in microseconds
`define EE_BYTE_EW_US 10000
`define EE_PAGE_ERASE_US 3500
`define EE_PAGE_WRITE_US 28000
`define EE_BYTE_EW_CYC (`EE_BYTE_EW_US * `EE_CLK_MHZ)
`define EE_PAGE_ERASE_CYC (`EE_PAGE_ERASE_US * `EE_CLK_MHZ)
`define EE_PAGE_BYTE_CYC ((`EE_PAGE_WRITE_US / 8) * `EE_CLK_MHZ)

`endif

// ### rtl/ee_pkg.sv
/*
 Types of the serial EEPROM bus slave: bus protocol and write cycle states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ee_pkg;
   typedef enum logic [3:0] {
      BS_IDLE, BS_ADDR, BS_WORD, BS_DATA, BS_ACK, BS_TX, BS_RACK, BS_IGNORE
   } ee_bus_state_e;
   typedef enum logic [1:0] {
      WS_IDLE, WS_ERASE, WS_PROG, WS_FLUSH
   } ee_wr_state_e;
endpackage

// ### rtl/ee_fifo.sv
/*
 Parameterised FIFO with valid/ready on both sides, holding pending write entries.
 Assumes DEPTH is a power of two and one synchronous active-high reset.
*/
`timescale 1ns/100ps
module ee_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic push, pop;

   assign in_ready_o = (wr_ff[AW] == rd_ff[AW]) || (wr_ff[AW-1:0] != rd_ff[AW-1:0]);
   assign out_valid_o = (wr_ff != rd_ff);
   assign out_data_o = mem_ff[rd_ff[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      nxt_wr = wr_ff + (AW+1)'(push);
      nxt_rd = rd_ff + (AW+1)'(pop);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end

   // storage holds no reset; contents are only read once written
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_ff[wr_ff[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// ### rtl/ee_bus_slave.sv
/*
 Protocol engine and storage of a 1024-byte two-wire bus EEPROM slave, with internal write cycle timing.
 Assumes scl/sda and strap pins arrive asynchronously and an external master drives the bus slowly (100 kHz).
*/
//
// Behaviour
// - sda falling while scl high starts transfer
// - sda rising while scl high stops transfer
// - sda change with scl high is control
// - one scl pulse per bit, sampled high
// - reads continue while master acknowledges
// - receiver acknowledges by holding sda low
// - missing master ack releases sda
// - address byte lsb one means read
// - protect pin blocks upper half data writes
// - write carries acknowledged word address byte
// - byte mode increments address, eight bytes
// - stop launches write cycle, 10 ms/byte in byte mode
// - no acknowledge while write cycle runs
// - page mode: eight bytes, erase then program
// - page write advances only low three bits
// - ninth page byte unacked, transfer discarded
// - bus ignored until write cycles finish
// - current, random and sequential reads supported
// - low eight address bits wrap per byte
// - address byte: type, select bit, page bits
// - bytes shifted most significant bit first
`timescale 1ns/100ps
`include "ee_params.svh"
module ee_bus_slave #(
   parameter logic [3:0] TYPE_CODE = 4'h5, // arbitrary value
   parameter logic [31:0] BYTE_EW_CYC = 32'(`EE_BYTE_EW_CYC),
   parameter logic [31:0] PAGE_ERASE_CYC = 32'(`EE_PAGE_ERASE_CYC),
   parameter logic [31:0] PAGE_BYTE_CYC = 32'(`EE_PAGE_BYTE_CYC)
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // two-wire bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // straps and mode
   input wire logic wp_i,
   input wire logic chip_select_pin_i,
   input wire logic page_mode_i,
   // status
   output logic busy_o
);
   localparam int AW = `EE_ADDR_W;

   logic [7:0] mem_ff [`EE_MEM_BYTES];
   logic [4:0] sync1_ff, sync2_ff;
   logic scl_d_ff, sda_d_ff;
   logic scl_s, sda_s, wp_s, cs_s, pm_s;
   logic scl_rise, scl_fall, start_det, stop_det;

   ee_pkg::ee_bus_state_e state_ff, nxt_state, after_ff, nxt_after;
   logic [3:0] cnt_ff, nxt_cnt, wcnt_ff, nxt_wcnt;
   logic [7:0] sh_ff, nxt_sh, tx_ff, nxt_tx;
   logic [AW-1:0] addr_ff, nxt_addr;
   logic oe_ff, nxt_oe, discard_ff, nxt_discard, mack_ff, nxt_mack;
   logic push;

   ee_pkg::ee_wr_state_e wst_ff, nxt_wst;
   logic [31:0] timer_ff, nxt_timer;
   logic busy_ff, nxt_busy, pop, mem_we;

   logic fifo_in_ready, fifo_out_valid;
   logic [`EE_FIFO_W-1:0] fifo_in_data, fifo_out_data;

   // next address: page mode turns over in 8 bytes, otherwise in 256; page bits never move
   function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a, input logic page);
      if (page) begin
         next_addr = {a[AW-1:3], a[2:0] + 3'h1};
      end else begin
         next_addr = {a[AW-1:8], a[7:0] + 8'h01};
      end
   endfunction

   // two-stage synchroniser; stage one feeds only stage two
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sync1_ff <= 5'h1F;
         sync2_ff <= 5'h1F;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         sync1_ff <= {scl_i, sda_i, wp_i, chip_select_pin_i, page_mode_i};
         sync2_ff <= sync1_ff;
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   assign {scl_s, sda_s, wp_s, cs_s, pm_s} = sync2_ff;
   assign scl_rise = scl_s && !scl_d_ff;
   assign scl_fall = !scl_s && scl_d_ff;
   assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
   assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

   // bus protocol
   always_comb begin
      nxt_state = state_ff;
      nxt_after = after_ff;
      nxt_cnt = cnt_ff;
      nxt_wcnt = wcnt_ff;
      nxt_sh = sh_ff;
      nxt_tx = tx_ff;
      nxt_addr = addr_ff;
      nxt_oe = oe_ff;
      nxt_discard = discard_ff;
      nxt_mack = mack_ff;
      push = 1'b0;
      fifo_in_data = {addr_ff, sh_ff};
      if (start_det) begin
         nxt_state = ee_pkg::BS_ADDR;
         nxt_cnt = 4'h0;
         nxt_oe = 1'b0;
      end else if (stop_det) begin
         nxt_state = ee_pkg::BS_IDLE;
         nxt_oe = 1'b0;
      end else begin
         unique case (state_ff)
            ee_pkg::BS_IDLE, ee_pkg::BS_IGNORE: begin
               nxt_oe = 1'b0;
            end
            ee_pkg::BS_ADDR, ee_pkg::BS_WORD, ee_pkg::BS_DATA: begin
               if (scl_rise) begin
                  nxt_sh = {sh_ff[6:0], sda_s};
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (scl_fall && cnt_ff == `EE_BITS_PER_BYTE) begin
                  nxt_cnt = 4'h0;
                  nxt_state = ee_pkg::BS_ACK;
                  if (state_ff == ee_pkg::BS_ADDR) begin
                     if (sh_ff[`EE_AB_TYPE_HI:`EE_AB_TYPE_LO] != TYPE_CODE || sh_ff[`EE_AB_CS] != cs_s) begin
                        nxt_state = ee_pkg::BS_IGNORE;
                     end else if (busy_ff) begin
                        nxt_state = ee_pkg::BS_IGNORE;
                     end else begin
                        nxt_oe = 1'b1;
                        nxt_addr = {sh_ff[`EE_AB_PAGE_HI:`EE_AB_PAGE_LO], addr_ff[7:0]};
                        if (sh_ff[`EE_AB_DIR] == `EE_DIR_READ) begin
                           nxt_after = ee_pkg::BS_TX;
                        end else begin
                           nxt_after = ee_pkg::BS_WORD;
                        end
                     end
                  end else if (state_ff == ee_pkg::BS_WORD) begin
                     nxt_oe = 1'b1;
                     nxt_addr = {addr_ff[AW-1:8], sh_ff};
                     nxt_after = ee_pkg::BS_DATA;
                     nxt_wcnt = 4'h0;
                     nxt_discard = 1'b0;
                  end else begin
                     nxt_after = ee_pkg::BS_DATA;
                     nxt_wcnt = wcnt_ff + 4'h1;
                     nxt_addr = next_addr(addr_ff, pm_s);
                     if (pm_s && wcnt_ff >= `EE_PAGE_BYTES) begin
                        nxt_discard = 1'b1;
                        nxt_wcnt = wcnt_ff;
                     end else if (wp_s && addr_ff[`EE_PROT_BIT]) begin
                        nxt_oe = 1'b0;
                     end else if (fifo_in_ready) begin
                        // full buffer withholds the acknowledge instead of losing the byte
                        nxt_oe = 1'b1;
                        push = 1'b1;
                     end
                  end
               end
            end
            ee_pkg::BS_ACK: begin
               if (scl_fall) begin
                  nxt_oe = 1'b0;
                  nxt_state = after_ff;
                  if (after_ff == ee_pkg::BS_TX) begin
                     nxt_tx = mem_ff[addr_ff];
                     nxt_oe = !mem_ff[addr_ff][7];
                     nxt_addr = next_addr(addr_ff, 1'b0);
                  end
               end
            end
            ee_pkg::BS_TX: begin
               if (scl_rise) begin
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_ff == `EE_BITS_PER_BYTE) begin
                     nxt_oe = 1'b0;
                     nxt_cnt = 4'h0;
                     nxt_state = ee_pkg::BS_RACK;
                  end else begin
                     nxt_tx = {tx_ff[6:0], 1'b0};
                     nxt_oe = !tx_ff[6];
                  end
               end
            end
            ee_pkg::BS_RACK: begin
               if (scl_rise) begin
                  nxt_mack = !sda_s;
               end else if (scl_fall) begin
                  if (mack_ff) begin
                     nxt_state = ee_pkg::BS_TX;
                     nxt_tx = mem_ff[addr_ff];
                     nxt_oe = !mem_ff[addr_ff][7];
                     nxt_addr = next_addr(addr_ff, 1'b0);
                  end else begin
                     nxt_state = ee_pkg::BS_IGNORE;
                     nxt_oe = 1'b0;
                  end
               end
            end
            default: begin
               nxt_state = ee_pkg::BS_IDLE;
               nxt_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_ff <= ee_pkg::BS_IDLE;
         after_ff <= ee_pkg::BS_IDLE;
         cnt_ff <= 4'h0;
         wcnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         tx_ff <= 8'h00;
         addr_ff <= '0;
         oe_ff <= 1'b0;
         discard_ff <= 1'b0;
         mack_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         after_ff <= nxt_after;
         cnt_ff <= nxt_cnt;
         wcnt_ff <= nxt_wcnt;
         sh_ff <= nxt_sh;
         tx_ff <= nxt_tx;
         addr_ff <= nxt_addr;
         oe_ff <= nxt_oe;
         discard_ff <= nxt_discard;
         mack_ff <= nxt_mack;
      end
   end

   ee_fifo #(
      .WIDTH(`EE_FIFO_W),
      .DEPTH(`EE_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_out_data)
   );

   // internal write cycle: drains the buffer one byte per programming slot, or one byte per clock in WS_FLUSH
   always_comb begin
      nxt_wst = wst_ff;
      nxt_timer = timer_ff;
      pop = 1'b0;
      mem_we = 1'b0;
      unique case (wst_ff)
         ee_pkg::WS_IDLE: begin
            if (stop_det && fifo_out_valid) begin
               nxt_timer = 32'h0;
               if (discard_ff) begin
                  nxt_wst = ee_pkg::WS_FLUSH;
               end else if (pm_s) begin
                  nxt_wst = ee_pkg::WS_ERASE;
                  nxt_timer = PAGE_ERASE_CYC;
               end else begin
                  nxt_wst = ee_pkg::WS_PROG;
               end
            end
         end
         ee_pkg::WS_ERASE: begin
            if (timer_ff == 32'h0) begin
               nxt_wst = ee_pkg::WS_PROG;
            end else begin
               nxt_timer = timer_ff - 32'h1;
            end
         end
         ee_pkg::WS_PROG: begin
            if (timer_ff != 32'h0) begin
               nxt_timer = timer_ff - 32'h1;
            end else if (fifo_out_valid) begin
               pop = 1'b1;
               mem_we = 1'b1;
               nxt_timer = pm_s ? PAGE_BYTE_CYC : BYTE_EW_CYC;
            end else begin
               nxt_wst = ee_pkg::WS_IDLE;
            end
         end
         ee_pkg::WS_FLUSH: begin
            pop = fifo_out_valid;
            if (!fifo_out_valid) begin
               nxt_wst = ee_pkg::WS_IDLE;
            end
         end
      endcase
      nxt_busy = (nxt_wst != ee_pkg::WS_IDLE);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wst_ff <= ee_pkg::WS_IDLE;
         timer_ff <= 32'h0;
         busy_ff <= 1'b0;
      end else begin
         wst_ff <= nxt_wst;
         timer_ff <= nxt_timer;
         busy_ff <= nxt_busy;
      end
   end

   // storage array, no reset
   always_ff @(posedge sys_clk_i) begin
      if (mem_we) begin
         mem_ff[fifo_out_data[`EE_FIFO_W-1:8]] <= fifo_out_data[7:0];
      end
   end

   // open drain: the pin is only ever pulled low
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_ff;
   assign busy_o = busy_ff;
endmodule

// ### dv/ee_bus_slave_asserts.sv
/*
 Port-level assertions for ee_bus_slave, bound into every instance.
 Assumes the bus lines change in step with sys_clk_i, as the bench drives them.
*/
`timescale 1ns/100ps
module ee_bus_slave_asserts #(
   parameter logic [3:0] TYPE_CODE = 4'h5
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // bus, straps and status
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic wp_i,
   input wire logic chip_select_pin_i,
   input wire logic page_mode_i,
   input wire logic busy_o
);
   logic scl_ff, sda_ff, start_w, ab_ok;
   logic [3:0] bit_ff, byte_ff, nxt_bit, nxt_byte;
   logic [7:0] sh_ff, ab_ff, nxt_sh, nxt_ab;
   assign start_w = scl_i && scl_ff && sda_ff && !sda_i;
   assign ab_ok = ab_ff[7:4] == TYPE_CODE && ab_ff[3] == chip_select_pin_i;
   always_comb begin
      nxt_bit = bit_ff;
      nxt_byte = byte_ff;
      nxt_sh = sh_ff;
      nxt_ab = ab_ff;
      if (rst_i || start_w) begin
         nxt_bit = 4'h0;
         nxt_byte = 4'h0;
      end else if (scl_i && !scl_ff) begin
         nxt_bit = (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
         nxt_sh = {sh_ff[6:0], sda_i};
         // saturate so long reads never alias back onto the address byte
         if (bit_ff == 4'h8 && byte_ff != 4'hF) nxt_byte = byte_ff + 4'h1;
         if (bit_ff == 4'h7 && byte_ff == 4'h0) nxt_ab = {sh_ff[6:0], sda_i};
      end
   end
   always_ff @(posedge sys_clk_i) begin
      scl_ff <= scl_i;
      sda_ff <= sda_i;
      bit_ff <= nxt_bit;
      byte_ff <= nxt_byte;
      sh_ff <= nxt_sh;
      ab_ff <= nxt_ab;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_ninth;
      $rose(scl_i) && bit_ff == 4'h8;
   endsequence
   a_pull_only: assert property (sda_o == 1'b0) else $error("data output not low");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !sda_oe_o && !busy_o)
      else $error("outputs active after reset");
   a_oe_steady: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
      else $error("data drive changed while clock high");
   a_busy_mute: assert property (busy_o |-> !sda_oe_o) else $error("drive during write cycle");
   a_busy_stop: assert property ($rose(busy_o) |-> scl_i && $past(scl_i, 3))
      else $error("write cycle began without stop");
   a_addr_match: assert property (s_ninth ##0 byte_ff == 4'h0 |-> sda_oe_o == (ab_ok && !busy_o))
      else $error("address acknowledge wrong");
   a_word_ack: assert property (s_ninth ##0 (byte_ff == 4'h1 && !ab_ff[0] && ab_ok && !busy_o) |-> sda_oe_o)
      else $error("word address not acknowledged");
   a_wp_block: assert property (s_ninth ##0 (byte_ff >= 4'h2 && !ab_ff[0] && wp_i && ab_ff[2]) |-> !sda_oe_o)
      else $error("protected byte acknowledged");
   a_page_limit: assert property (s_ninth ##0 (byte_ff >= 4'hA && !ab_ff[0] && page_mode_i) |-> !sda_oe_o)
      else $error("ninth page byte acknowledged");
   a_nack_free: assert property (s_ninth ##0 (byte_ff != 4'h0 && ab_ff[0] && sda_i) |=> !sda_oe_o [*8])
      else $error("line held after master nack");
endmodule
bind ee_bus_slave ee_bus_slave_asserts #(.TYPE_CODE(TYPE_CODE)) u_asserts (.sys_clk_i(sys_clk_i),
   .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i),
   .chip_select_pin_i(chip_select_pin_i), .page_mode_i(page_mode_i), .busy_o(busy_o));

// ### dv/ee_master_model.sv
/*
 Two-wire bus master model, driven by task calls from the bench.
 Assumes pull-ups on both lines; an 80 ns bit time, scaled down from the slow real bus.
*/
`timescale 1ns/100ps
module ee_master_model (
   // clock
   input wire logic sys_clk_i,
   // bus, 1 = released
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   // also serves as repeated start; sda falls only from an idle-looking bus
   task automatic start_c();
      sda_o <= 1'b1;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= 1'b0;
      tick(4);
      scl_o <= 1'b0;
      tick(2);
   endtask
   task automatic stop_c();
      sda_o <= 1'b0;
      tick(3);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= 1'b1;
      tick(4);
   endtask
   // data moves only in the low phase
   task automatic bit_x(input logic b, output logic r);
      sda_o <= b;
      tick(3);
      scl_o <= 1'b1;
      tick(2);
      r = sda_i;
      tick(1);
      scl_o <= 1'b0;
      tick(2);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = !r;
   endtask
   task automatic get_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(!more, r);
   endtask
endmodule

// ### dv/tb_ee_bus_slave.sv
/*
 Self-checking bench for ee_bus_slave with a bus master model.
 Assumes shortened write cycle counts and the designer's type code.
*/
`timescale 1ns/100ps
module tb_ee_bus_slave;
   localparam logic [3:0] TC = 4'h5; // arbitrary value, must equal the device's
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wp = 1'b0;
   logic cs = 1'b1;
   logic pm = 1'b0;
   logic scl, sda_m, oe, busy;
   wire sda_w = sda_m & ~oe;
   int fail_count = 0;
   int n_tests = 0;
   logic [7:0] expv [0:8];
   always #5 clk = ~clk;
   ee_master_model m (.sys_clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
   ee_bus_slave #(.TYPE_CODE(TC), .BYTE_EW_CYC(32'h32), .PAGE_ERASE_CYC(32'h14), .PAGE_BYTE_CYC(32'h14)) dut (
      .sys_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(oe), .wp_i(wp),
      .chip_select_pin_i(cs), .page_mode_i(pm), .busy_o(busy));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   function automatic logic [7:0] ab(input logic [1:0] pg, input logic rd);
      return {TC, 1'h1, pg, rd};
   endfunction
   task automatic snd(input logic [7:0] b, input logic exp_ack);
      logic a;
      m.put_byte(b, a);
      chk(8'(a), 8'(exp_ack));
   endtask
   task automatic wr(input logic [1:0] pg, input logic [7:0] wa, input int n, input int n_ack);
      m.start_c();
      snd(ab(pg, 1'h0), 1'h1);
      snd(wa, 1'h1);
      for (int i = 0; i < n; i++) snd(expv[i], i < n_ack);
      m.stop_c();
   endtask
   // random read when seek is set, else from the kept address
   task automatic rd(input logic [1:0] pg, input logic [7:0] wa, input int n, input logic seek);
      logic [7:0] d;
      if (seek) begin
         m.start_c();
         snd(ab(pg, 1'h0), 1'h1);
         snd(wa, 1'h1);
      end
      m.start_c();
      snd(ab(pg, 1'h1), 1'h1);
      for (int i = 0; i < n; i++) begin
         m.get_byte(i < n - 1, d);
         chk(d, expv[i]);
      end
      m.stop_c();
   endtask
   task automatic idle();
      for (int k = 0; k < 3000 && busy !== 1'h0; k++) @(posedge clk);
      chk(8'(busy), 8'h00);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      wp <= 1'h1;
      expv[0] = 8'hA1;
      expv[1] = 8'hA2;
      expv[2] = 8'hA3;
      wr(2'h1, 8'hFE, 3, 3);
      repeat (4) @(posedge clk);
      chk(8'(busy), 8'h01);
      m.start_c();
      snd(ab(2'h1, 1'h1), 1'h0);
      m.stop_c();
      idle();
      rd(2'h1, 8'hFE, 2, 1'h1);
      expv[0] = 8'hA3;
      rd(2'h1, 8'h00, 1, 1'h0);
      $display("test byte write done");
      wr(2'h2, 8'h10, 1, 0);
      repeat (4) @(posedge clk);
      chk(8'(busy), 8'h00);
      wp <= 1'h0;
      cs <= 1'h0;
      m.start_c();
      snd(ab(2'h0, 1'h0), 1'h0);
      cs <= 1'h1;
      m.start_c();
      snd({~TC, 4'h8}, 1'h0);
      m.stop_c();
      $display("test refusals done");
      pm <= 1'h1;
      for (int i = 0; i < 8; i++) expv[i] = 8'h30 + 8'(i);
      wr(2'h3, 8'h0E, 8, 8);
      idle();
      for (int i = 0; i < 8; i++) expv[i] = 8'h30 + 8'((i + 2) % 8);
      rd(2'h3, 8'h08, 8, 1'h1);
      for (int i = 0; i < 9; i++) expv[i] = 8'h50 + 8'(i);
      wr(2'h3, 8'h08, 9, 8);
      // dropping the eight buffered bytes keeps busy up for a few clocks; programming would last far longer
      repeat (16) @(posedge clk);
      chk(8'(busy), 8'h00);
      for (int i = 0; i < 8; i++) expv[i] = 8'h30 + 8'((i + 2) % 8);
      rd(2'h3, 8'h08, 8, 1'h1);
      $display("test page write done");
      give_verdict();
   end
   // the whole sequence needs well under 10000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      $display("FAIL %0t watchdog expired", $time);
      give_verdict();
   end
endmodule
